// File: logic/rtsa_device.sv
`default_nettype none
// Notes on behaviour
// R1 - Select rise: mode, address, then bytes
// R2 - Partial write byte dropped at select fall
// R3 - Earlier bytes kept; write fail flag set
// R4 - All fields shifted LSB first
// R5 - Mode 3 selects write access
// R6 - Each full byte stored, address increments
// R7 - Address wraps from F to 0
// R8 - Mode C selects read access
// R9 - Read outputs byte, increments per eight
// R10 - Other mode: ignore rest, stay input
// R11 - Test bit cleared while select low
// R12 - Reset bit cleared by select low
// R13 - Sample and shift on rising clock
// R14 - Select low: release line, clear counters
module rtsa_device (
    input wire logic clk,
    input wire logic rst_n,
    rtsa_if.dev link,
    output logic reg_we,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic write_fail_flag,
    input wire logic write_fail_clr,
    output logic test_clr,
    output logic reset_bit_clr
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sel_q, sel_d, clk_q, clk_d, dat_q, dat_d;
    always_comb begin
        sel_d = {sel_q[1:0], link.sel};
        clk_d = {clk_q[1:0], link.sclk};
        dat_d = {dat_q[1:0], link.data};
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_q <= 3'h0;
            clk_q <= 3'h0;
            dat_q <= 3'h0;
        end else begin
            sel_q <= sel_d;
            clk_q <= clk_d;
            dat_q <= dat_d;
        end
    end
    logic sel_s, sclk_s, rise, data_s;
    logic sel_sq, sel_sd, sclk_sq, sclk_sd;
    always_comb begin
        sel_sd = (sel_q[1] == sel_q[2]) ? sel_q[2] : sel_sq;
        sclk_sd = (clk_q[1] == clk_q[2]) ? clk_q[2] : sclk_sq;
        sel_s = sel_sq;
        sclk_s = sclk_sq;
        rise = sclk_sd & ~sclk_sq & sel_sq;
        data_s = dat_q[2];
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_sq <= 1'b0;
            sclk_sq <= 1'b0;
        end else begin
            sel_sq <= sel_sd;
            sclk_sq <= sclk_sd;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    rtsa_pkg::rtsa_state_e st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] addr_q, addr_d;
    logic rd_q, rd_d, out_q, out_d, oen_q, oen_d, ign_q, ign_d;
    logic we_q, we_d, wf_q, wf_d;
    logic [7:0] wd_q, wd_d;
    logic [7:0] nsh;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        addr_d = addr_q;
        rd_d = rd_q;
        out_d = out_q;
        oen_d = oen_q;
        ign_d = ign_q;
        we_d = 1'b0;
        wd_d = wd_q;
        wf_d = wf_q & ~write_fail_clr;
        nsh = {data_s, sh_q[7:1]}; // [R4]
        if (!sel_s) begin
            st_d = rtsa_pkg::RTSA_MODE; // [R14]
            cnt_d = 3'h0;
            oen_d = 1'b1;
            rd_d = 1'b0;
            ign_d = 1'b0;
            if (st_q == rtsa_pkg::RTSA_DATA && !rd_q && cnt_q != 3'h0) begin
                wf_d = 1'b1; // [R2] [R3]
            end
        end else if (rise && !ign_q) begin // [R13]
            case (st_q)
                rtsa_pkg::RTSA_MODE: begin
                    sh_d = nsh;
                    cnt_d = 3'(cnt_q + 3'h1);
                    if (cnt_q == 3'(rtsa_pkg::CODE_BITS - 1)) begin // [R1]
                        cnt_d = 3'h0;
                        st_d = rtsa_pkg::RTSA_ADDR;
                        if (nsh[7:4] == rtsa_pkg::MODE_READ) begin
                            rd_d = 1'b1; // [R8]
                        end else if (nsh[7:4] != rtsa_pkg::MODE_WRITE) begin
                            ign_d = 1'b1; // [R10]
                        end // [R5]
                    end
                end
                rtsa_pkg::RTSA_ADDR: begin
                    sh_d = nsh;
                    cnt_d = 3'(cnt_q + 3'h1);
                    if (cnt_q == 3'(rtsa_pkg::CODE_BITS - 1)) begin
                        cnt_d = 3'h0;
                        addr_d = nsh[7:4];
                        st_d = rtsa_pkg::RTSA_DATA;
                    end
                end
                rtsa_pkg::RTSA_DATA: begin
                    cnt_d = 3'(cnt_q + 3'h1);
                    if (rd_q) begin
                        oen_d = 1'b0; // [R9]
                        out_d = reg_rdata[cnt_q];
                        if (cnt_q == 3'(rtsa_pkg::BYTE_BITS - 1)) begin
                            addr_d = 4'(addr_q + 4'h1); // [R7]
                        end
                    end else begin
                        sh_d = nsh;
                        if (cnt_q == 3'(rtsa_pkg::BYTE_BITS - 1)) begin
                            we_d = 1'b1; // [R6]
                            wd_d = nsh;
                        end
                    end
                end
                default: st_d = rtsa_pkg::RTSA_MODE;
            endcase
        end
        if (we_q) begin
            addr_d = 4'(addr_q + 4'h1); // [R7]
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= rtsa_pkg::RTSA_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            addr_q <= 4'h0;
            rd_q <= 1'b0;
            out_q <= 1'b0;
            oen_q <= 1'b1;
            ign_q <= 1'b0;
            we_q <= 1'b0;
            wd_q <= 8'h00;
            wf_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            out_q <= out_d;
            oen_q <= oen_d;
            ign_q <= ign_d;
            we_q <= we_d;
            wd_q <= wd_d;
            wf_q <= wf_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        reg_we = we_q;
        reg_addr = addr_q;
        reg_wdata = wd_q;
        write_fail_flag = wf_q;
        link.data_dev_o = out_q;
        link.data_dev_oe_n = oen_q | ~sel_s; // [R14] [R10]
        test_clr = ~sel_s; // [R11]
        reset_bit_clr = ~sel_s; // [R12]
    end
endmodule
`default_nettype wire

// File: logic/rtsa_host.sv
`default_nettype none
module rtsa_host #(
    parameter int MAX_BYTES = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    rtsa_if.host link,
    input wire logic start,
    input wire logic rd,
    input wire logic [3:0] addr,
    input wire logic [4:0] nbytes,
    input wire logic [7:0] wdata,
    output logic wdata_take,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic busy
);
    if (MAX_BYTES < 1 || MAX_BYTES > 31) begin : g_bad_max
        $error("MAX_BYTES out of range");
    end
    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    logic [2:0] div_q, div_d;
    logic act_q, act_d, sck_q, sck_d, oen_q, oen_d, dout_q, dout_d;
    logic [3:0] bit_q, bit_d;
    logic [4:0] left_q, left_d;
    logic [7:0] sh_q, sh_d, rd_q2, rd_d2;
    logic hdr_q, hdr_d, rdm_q, rdm_d, rv_q, rv_d, tk_q, tk_d;
    logic tick;
    always_comb begin
        div_d = 3'(div_q + 3'h1);
        tick = (div_q == 3'(rtsa_pkg::LINK_DIV - 1));
        act_d = act_q;
        sck_d = sck_q;
        oen_d = oen_q;
        dout_d = dout_q;
        bit_d = bit_q;
        left_d = left_q;
        sh_d = sh_q;
        rd_d2 = rd_q2;
        hdr_d = hdr_q;
        rdm_d = rdm_q;
        rv_d = 1'b0;
        tk_d = 1'b0;
        if (!act_q) begin
            if (start) begin
                act_d = 1'b1; // [R1]
                hdr_d = 1'b1;
                rdm_d = rd;
                sh_d = {addr, rd ? rtsa_pkg::MODE_READ
                    : rtsa_pkg::MODE_WRITE}; // [R5] [R8]
                bit_d = 4'h0;
                left_d = nbytes;
                oen_d = 1'b0;
                dout_d = rd ? rtsa_pkg::MODE_READ[0]
                    : rtsa_pkg::MODE_WRITE[0];
                div_d = 3'h0;
            end
        end else if (tick) begin
            if (!sck_q) begin
                sck_d = 1'b1; // [R13]
            end else begin
                sck_d = 1'b0;
                // Read bit settles after the rise; take it at the fall
                if (rdm_q && !hdr_q) begin
                    rd_d2 = {link.data, rd_q2[7:1]}; // [R4] [R13]
                end
                bit_d = 4'(bit_q + 4'h1);
                sh_d = {1'b0, sh_q[7:1]};
                dout_d = sh_q[1];
                if (bit_q == 4'(rtsa_pkg::BYTE_BITS - 1)) begin
                    bit_d = 4'h0;
                    if (!hdr_q) begin
                        left_d = 5'(left_q - 5'h1);
                        rv_d = rdm_q;
                    end
                    hdr_d = 1'b0;
                    if (rdm_q) begin
                        oen_d = 1'b1;
                    end else begin
                        sh_d = wdata;
                        dout_d = wdata[0];
                        tk_d = 1'b1;
                    end
                    if (!hdr_q ? (left_q == 5'h1) : (left_q == 5'h0)) begin
                        act_d = 1'b0;
                        oen_d = 1'b1;
                        tk_d = 1'b0;
                    end
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= 3'h0;
            act_q <= 1'b0;
            sck_q <= 1'b0;
            oen_q <= 1'b1;
            dout_q <= 1'b0;
            bit_q <= 4'h0;
            left_q <= 5'h0;
            sh_q <= 8'h00;
            rd_q2 <= 8'h00;
            hdr_q <= 1'b0;
            rdm_q <= 1'b0;
            rv_q <= 1'b0;
            tk_q <= 1'b0;
        end else begin
            div_q <= div_d;
            act_q <= act_d;
            sck_q <= sck_d;
            oen_q <= oen_d;
            dout_q <= dout_d;
            bit_q <= bit_d;
            left_q <= left_d;
            sh_q <= sh_d;
            rd_q2 <= rd_d2;
            hdr_q <= hdr_d;
            rdm_q <= rdm_d;
            rv_q <= rv_d;
            tk_q <= tk_d;
        end
    end
    always_comb begin
        link.sel = act_q;
        link.sclk = sck_q;
        link.data_host_o = dout_q;
        link.data_host_oe_n = oen_q;
        wdata_take = tk_q;
        rdata = rd_q2;
        rdata_valid = rv_q;
        busy = act_q;
    end
endmodule
`default_nettype wire

// File: pkg/rtsa_if.sv
`default_nettype none
interface rtsa_if;
    logic sel;
    logic sclk;
    logic data_host_o;
    logic data_host_oe_n;
    logic data_dev_o;
    logic data_dev_oe_n;
    logic data;
    always_comb begin
        if (!data_host_oe_n) begin
            data = data_host_o;
        end else if (!data_dev_oe_n) begin
            data = data_dev_o;
        end else begin
            data = 1'b0;
        end
    end
    modport host (output sel, output sclk, output data_host_o,
        output data_host_oe_n, input data);
    modport dev (input sel, input sclk, output data_dev_o,
        output data_dev_oe_n, input data);
endinterface
`default_nettype wire

// File: pkg/rtsa_pkg.sv
`default_nettype none
package rtsa_pkg;
    localparam logic [3:0] MODE_WRITE = 4'h3;
    localparam logic [3:0] MODE_READ = 4'hc;
    localparam int CODE_BITS = 4;
    localparam int BYTE_BITS = 8;
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL2_ADDR = 4'hf;
    localparam int TEST_BIT = 6;
    localparam int RESET_BIT = 4;
    localparam int LINK_DIV = 8;
    typedef enum logic [1:0] {
        RTSA_IDLE = 2'b00,
        RTSA_MODE = 2'b01,
        RTSA_ADDR = 2'b11,
        RTSA_DATA = 2'b10
    } rtsa_state_e;
endpackage
`default_nettype wire

// File: tb/rtsa_monitor.sv
`default_nettype none
module rtsa_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sel,
    input wire logic sclk,
    input wire logic data_host_o,
    input wire logic data_host_oe_n,
    input wire logic data_dev_o,
    input wire logic data_dev_oe_n,
    input wire logic data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic [3:0] mode_q;
    // ----------------------------------------
    // Rise count and mode code per access
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || !sel) begin
            cnt_q <= 8'h00;
            mode_q <= 4'h0;
        end else if ($rose(sclk)) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q < 8'h04) begin
                mode_q[cnt_q[1:0]] <= data;
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_idle_release: assert property (!sel [*6] |-> data_dev_oe_n)
        else $error("device drives while deselected");
    a_no_contend: assert property (data_host_oe_n || data_dev_oe_n)
        else $error("both ends drive data");
    a_sclk_idle: assert property (!sel |-> !sclk)
        else $error("shift clock high while deselected");
    a_sclk_half: assert property ($rose(sclk) |=> sclk [*7])
        else $error("shift clock high phase too short");
    a_header_quiet: assert property (sel && cnt_q < 8'h08 |->
        data_dev_oe_n)
        else $error("device drives during header");
    a_write_quiet: assert property (sel && cnt_q >= 8'h04 &&
        mode_q != 4'hc |-> data_dev_oe_n)
        else $error("device drives outside read");
    a_read_driven: assert property (sel && mode_q == 4'hc &&
        cnt_q >= 8'h0a |-> data_host_oe_n && !data_dev_oe_n)
        else $error("read data not driven by device");
    a_header_driven: assert property (sel && cnt_q < 8'h08 |->
        !data_host_oe_n)
        else $error("host not driving header");
    a_frame_whole: assert property ($fell(sel) |->
        cnt_q[2:0] == 3'h0 && cnt_q >= 8'h08)
        else $error("access ended on partial unit");
    c_write: cover property (sel && cnt_q == 8'h10 && mode_q == 4'h3);
    c_read: cover property (sel && cnt_q == 8'h10 && mode_q == 4'hc);
    c_end: cover property ($fell(sel) && cnt_q > 8'h10);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0, rd = 1'b0, take, rv, busy;
    logic [3:0] addr = 4'h0;
    logic [4:0] nbytes = 5'h00;
    logic [7:0] wdata = 8'h00, rdata;
    logic we, we_b, wff, wff_b, tc, tc_b, rc, rc_b;
    logic wfc = 1'b0, wfc_b = 1'b0, drove = 1'b0;
    logic [3:0] ra, ra_b;
    logic [7:0] wd, wd_b;
    logic [7:0] mem [16];
    logic [7:0] wq [20];
    logic [7:0] rq [$];
    logic wb [$];
    int bad_count = 0, n_checks = 0;
    rtsa_if lk();
    rtsa_if lk2();
    always #4 clk = ~clk;
    rtsa_host i_rtsa_host (.clk(clk), .rst_n(rst_n), .link(lk), .start(start),
        .rd(rd), .addr(addr), .nbytes(nbytes), .wdata(wdata),
        .wdata_take(take), .rdata(rdata), .rdata_valid(rv), .busy(busy));
    rtsa_device i_rtsa_device (.clk(clk), .rst_n(rst_n), .link(lk),
        .reg_we(we), .reg_addr(ra), .reg_wdata(wd), .reg_rdata(mem[ra]),
        .write_fail_flag(wff), .write_fail_clr(wfc), .test_clr(tc),
        .reset_bit_clr(rc));
    rtsa_device i_rtsa_device_b (.clk(clk), .rst_n(rst_n), .link(lk2),
        .reg_we(we_b), .reg_addr(ra_b), .reg_wdata(wd_b),
        .reg_rdata(mem[ra_b]), .write_fail_flag(wff_b),
        .write_fail_clr(wfc_b), .test_clr(tc_b), .reset_bit_clr(rc_b));
    rtsa_monitor i_rtsa_monitor (.clk(clk), .rst_n(rst_n), .sel(lk.sel),
        .sclk(lk.sclk), .data_host_o(lk.data_host_o),
        .data_host_oe_n(lk.data_host_oe_n), .data_dev_o(lk.data_dev_o),
        .data_dev_oe_n(lk.data_dev_oe_n), .data(lk.data));
    // ----------------------------------------
    // Register model and wire capture
    // ----------------------------------------
    always @(posedge clk) begin
        if (we) mem[ra] <= wd;
        if (we_b) mem[ra_b] <= wd_b;
        if (!lk2.data_dev_oe_n) drove <= 1'b1;
    end
    always @(posedge lk.sclk) if (lk.sel) wb.push_back(lk.data);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] wbyte(int k);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) b[i] = wb[8 * k + i];
        return b;
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic xfer(logic r, logic [3:0] a, logic [4:0] n);
        int k, t;
        wb.delete();
        rq.delete();
        repeat (10) @(negedge clk);
        start = 1'b1;
        rd = r;
        addr = a;
        nbytes = n;
        wdata = wq[0];
        k = 0;
        @(negedge clk);
        start = 1'b0;
        for (t = 0; t < 6000; t++) begin
            if (take === 1'b1) begin
                k++;
                wdata = wq[k];
            end
            if (rv === 1'b1) rq.push_back(rdata);
            if (busy === 1'b0) break;
            @(negedge clk);
        end
        if (t == 6000) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic sbit(logic b);
        lk2.data_host_o = b;
        #31.25 lk2.sclk = 1'b1;
        #62.5 lk2.sclk = 1'b0;
        #31.25;
    endtask
    task automatic frame(logic [7:0] hdr, logic [7:0] d, int nb);
        lk2.sel = 1'b1;
        lk2.data_host_oe_n = 1'b0;
        #200;
        for (int i = 0; i < 8; i++) sbit(hdr[i]);
        for (int i = 0; i < 8; i++) sbit(d[i]);
        chk("test_clr", {7'h00, tc_b}, 8'h00);
        for (int i = 0; i < nb; i++) sbit(1'b1);
        #200 lk2.sel = 1'b0;
        lk2.data_host_oe_n = 1'b1;
        repeat (10) @(negedge clk);
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        lk2.sel = 1'b0;
        lk2.sclk = 1'b0;
        lk2.data_host_o = 1'b0;
        lk2.data_host_oe_n = 1'b1;
        for (int i = 0; i < 16; i++) mem[i] = 8'h10 + 8'(i);
        for (int i = 0; i < 20; i++) wq[i] = 8'h00;
        wq[0] = 8'ha5;
        wq[1] = 8'h3c;
        wq[2] = 8'h96;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        xfer(1'b0, 4'he, 5'h03);
        chk("wire bits", 8'(wb.size()), 8'h20);
        chk("wire header", wbyte(0), 8'he3);
        chk("wire byte", wbyte(1), 8'ha5);
        chk("mem e", mem[14], 8'ha5);
        chk("mem f", mem[15], 8'h3c);
        chk("mem 0", mem[0], 8'h96);
        chk("no fail a", {7'h00, wff}, 8'h00);
        $display("test write done");
        xfer(1'b1, 4'hf, 5'h03);
        chk("wire rd header", wbyte(0), 8'hfc);
        chk("read count", 8'(rq.size()), 8'h03);
        chk("read f", rq[0], 8'h3c);
        chk("read 0", rq[1], 8'h96);
        chk("read 1", rq[2], 8'h11);
        $display("test read done");
        frame(8'h53, 8'h7e, 3);
        chk("mem 5", mem[5], 8'h7e);
        chk("mem 6", mem[6], 8'h16);
        chk("fail flag", {7'h00, wff_b}, 8'h01);
        chk("test_clr low", {7'h00, tc_b}, 8'h01);
        chk("reset_clr low", {7'h00, rc_b}, 8'h01);
        chk("released", {7'h00, lk2.data_dev_oe_n}, 8'h01);
        wfc_b = 1'b1;
        @(negedge clk);
        wfc_b = 1'b0;
        @(negedge clk);
        chk("fail clr", {7'h00, wff_b}, 8'h00);
        $display("test abort done");
        frame(8'hca, 8'hff, 8);
        chk("bad mode mem", mem[12], 8'h1c);
        chk("bad mode drive", {7'h00, drove}, 8'h00);
        chk("no fail", {7'h00, wff_b}, 8'h00);
        $display("test bad mode done");
        close_out();
    end
endmodule
`default_nettype wire
